// File: verilog/i2cm_pkg.sv
// Constants and carrier types for the I2C master sequencer.
// Assumes a 32-bit APB slave port and open-drain SCL/SDA pins.
package i2cm_pkg;

   // Register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_BAUD = 8'h08;
   localparam logic [7:0] OFS_DATA = 8'h0c;

   // Control register field positions
   localparam int CTL_START = 0;
   localparam int CTL_RESTART = 1;
   localparam int CTL_STOP = 2;
   localparam int CTL_RECEIVE = 3;
   localparam int CTL_ACK = 4;
   localparam int CTL_ACK_LEVEL = 5;

   // Status register field positions
   localparam int STA_PEER_ACK = 0;
   localparam int STA_BUF_FULL = 1;
   localparam int STA_WR_COLL = 2;
   localparam int STA_RX_OVF = 3;
   localparam int STA_SER_INT = 4;
   localparam int STA_BUS_COLL = 5;
   localparam int STA_START_DET = 6;
   localparam int STA_STOP_DET = 7;
   localparam int STA_BUSY = 8;

   // Reset values
   localparam logic [7:0] BAUD_RESET = 8'h09;
   localparam logic [7:0] BYTE_RESET = 8'h00;

   // Bit index of the acknowledge slot within a byte
   localparam logic [3:0] ACK_SLOT = 4'h8;
   localparam logic [3:0] LAST_BIT = 4'h7;

   typedef enum logic [4:0] {
      ST_IDLE = 5'b00000,
      ST_START_WAIT = 5'b00001,
      ST_START_HOLD = 5'b00011,
      ST_RS_LOW = 5'b00010,
      ST_RS_SDA_HI = 5'b00110,
      ST_RS_RISE = 5'b00111,
      ST_RS_BOTH_HI = 5'b00101,
      ST_RS_SDA_LO = 5'b00100,
      ST_TX_LOW = 5'b01100,
      ST_TX_RISE = 5'b01101,
      ST_TX_HIGH = 5'b01111,
      ST_RX_LOW = 5'b01110,
      ST_RX_RISE = 5'b01010,
      ST_RX_HIGH = 5'b01011,
      ST_ACK_LOW = 5'b01001,
      ST_ACK_RISE = 5'b01000,
      ST_ACK_HIGH = 5'b11000,
      ST_SP_LOW = 5'b11001,
      ST_SP_RISE = 5'b11011,
      ST_SP_HIGH = 5'b11010,
      ST_SP_END = 5'b11110
   } i2cm_state_t;

   // Sampled bus lines
   typedef struct packed {
      logic scl;
      logic sda;
   } i2cm_lines_t;

   // One-cycle events from the sequencer to the flag logic
   typedef struct packed {
      logic start_det;
      logic stop_det;
      logic ser_int;
      logic bus_coll;
      logic bf_clr;
      logic rx_done;
      logic ack_cap;
      logic ack_val;
   } i2cm_ev_t;

endpackage

// File: verilog/i2cm_sequencer.sv
// I2C master sequencer: start, repeated start, stop, acknowledge,
// byte transmit and byte receive, with an APB register slave.
// Assumes open-drain pins with external pull-ups; pins are asynchronous.
// Notes on behaviour
// - Start request with both lines high reloads baud counter and counts.
// - Lines still high at expiry: pull data low, set start-detected.
// - One more period after start edge, then clear request, hold data low.
// - Line low at start or clock drops early: abort, collision, idle.
// - Repeated start written while busy is ignored.
// - Restart pulls clock low, releases data one period, releases clock.
// - Both high one period, data low one period, clock low, clear.
// - Restart sets start-detected on the start edge, interrupt at end.
// - Data low at clock rise or clock low early: restart collision.
// - Buffer write sets buffer-full and starts shifting the byte.
// - Bits change after clock falls; clock low one period, high one.
// - After the eighth bit falls, clear buffer-full and release data.
// - Ninth-bit level goes into the peer acknowledge status bit.
// - After ninth clock set interrupt, stop counting, clock low.
// - Buffer write during a sequence is dropped and sets write collision.
// - Receive request is ignored unless the sequencer is idle.
// - Receive toggles clock each rollover and shifts data in.
// - After eighth receive fall: clear request, load buffer, flags, idle.
// - Receive buffer-full sets on buffer load, clears on buffer read.
// - New byte while buffer-full still set raises receive overflow.
// - Stop or restart ends a transfer; interrupt when complete.
// - Ack sequence drives level one period, clock high one period, idle.
// - Stop: data low, clock up, data up, then interrupt, and stop-detected in the same cycle if both lines are high.
//
// Our own choices: the address map and the APB register port.
module i2cm_sequencer #(
   parameter int BAUD_W = 8
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic scl_in,
   output logic scl_out,
   output logic scl_oe_n,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_n
);

   i2cm_pkg::i2cm_state_t state_reg;
   i2cm_pkg::i2cm_lines_t meta_reg;
   i2cm_pkg::i2cm_lines_t line_reg;
   i2cm_pkg::i2cm_ev_t ev_reg;
   logic [BAUD_W-1:0] cnt_reg;
   logic [BAUD_W-1:0] baud_reg;
   logic [5:0] req_reg;
   logic [7:0] buf_reg;
   logic [7:0] shift_reg;
   logic [3:0] bit_reg;
   logic scl_drv_reg;
   logic sda_drv_reg;
   logic buf_full_reg;
   logic rx_byte_reg;
   logic peer_ack_reg;
   logic wr_coll_reg;
   logic rx_ovf_reg;
   logic ser_int_reg;
   logic bus_coll_reg;
   logic start_det_reg;
   logic stop_det_reg;
   logic [31:0] prdata_reg;
   logic pslverr_reg;
   logic wr_acc;
   logic rd_acc;
   logic setup;
   logic idle;
   logic expired;
   logic [7:0] status_w1c;

   assign setup = psel && !penable;
   assign wr_acc = psel && penable && pwrite;
   assign rd_acc = psel && penable && !pwrite;
   assign idle = state_reg == i2cm_pkg::ST_IDLE;
   assign expired = cnt_reg == '0;
   assign status_w1c = (wr_acc && paddr == i2cm_pkg::OFS_STATUS) ?
      pwdata[7:0] : 8'h00;

   assign pready = 1'b1;
   assign prdata = prdata_reg;
   assign pslverr = pslverr_reg;
   assign scl_out = 1'b0;
   assign sda_out = 1'b0;
   assign scl_oe_n = !scl_drv_reg;
   assign sda_oe_n = !sda_drv_reg;

   // Two-stage synchroniser on both bus lines
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_reg <= '1;
         line_reg <= '1;
      end else begin
         meta_reg <= '{scl: scl_in, sda: sda_in};
         line_reg <= meta_reg;
      end
   end

   // Baud reload register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         baud_reg <= BAUD_W'(i2cm_pkg::BAUD_RESET);
      end else if (wr_acc && paddr == i2cm_pkg::OFS_BAUD) begin
         baud_reg <= pwdata[BAUD_W-1:0];
      end
   end

   // Bus sequencer: state, baud counter, pin drives and requests
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= i2cm_pkg::ST_IDLE;
         cnt_reg <= '0;
         req_reg <= '0;
         buf_reg <= i2cm_pkg::BYTE_RESET;
         shift_reg <= i2cm_pkg::BYTE_RESET;
         bit_reg <= '0;
         scl_drv_reg <= 1'b0;
         sda_drv_reg <= 1'b0;
         ev_reg <= '0;
      end else begin
         ev_reg <= '0;
         if (!expired) begin
            cnt_reg <= cnt_reg - 1'b1;
         end
         case (state_reg)
            i2cm_pkg::ST_IDLE: begin
               if (wr_acc && paddr == i2cm_pkg::OFS_DATA) begin
                  buf_reg <= pwdata[7:0];
                  shift_reg <= pwdata[7:0];
                  bit_reg <= '0;
                  scl_drv_reg <= 1'b1;
                  cnt_reg <= baud_reg;
                  state_reg <= i2cm_pkg::ST_TX_LOW;
               end else if (wr_acc && paddr == i2cm_pkg::OFS_CTRL) begin
                  req_reg[i2cm_pkg::CTL_ACK_LEVEL] <=
                     pwdata[i2cm_pkg::CTL_ACK_LEVEL];
                  if (pwdata[i2cm_pkg::CTL_START]) begin
                     if (line_reg.scl && line_reg.sda) begin
                        req_reg[i2cm_pkg::CTL_START] <= 1'b1;
                        cnt_reg <= baud_reg;
                        state_reg <= i2cm_pkg::ST_START_WAIT;
                     end else begin
                        ev_reg.bus_coll <= 1'b1;
                     end
                  end else if (pwdata[i2cm_pkg::CTL_RESTART]) begin
                     req_reg[i2cm_pkg::CTL_RESTART] <= 1'b1;
                     scl_drv_reg <= 1'b1;
                     state_reg <= i2cm_pkg::ST_RS_LOW;
                  end else if (pwdata[i2cm_pkg::CTL_STOP]) begin
                     req_reg[i2cm_pkg::CTL_STOP] <= 1'b1;
                     scl_drv_reg <= 1'b1;
                     sda_drv_reg <= 1'b1;
                     cnt_reg <= baud_reg;
                     state_reg <= i2cm_pkg::ST_SP_LOW;
                  end else if (pwdata[i2cm_pkg::CTL_RECEIVE]) begin
                     req_reg[i2cm_pkg::CTL_RECEIVE] <= 1'b1;
                     scl_drv_reg <= 1'b1;
                     sda_drv_reg <= 1'b0;
                     bit_reg <= '0;
                     cnt_reg <= baud_reg;
                     state_reg <= i2cm_pkg::ST_RX_LOW;
                  end else if (pwdata[i2cm_pkg::CTL_ACK]) begin
                     req_reg[i2cm_pkg::CTL_ACK] <= 1'b1;
                     scl_drv_reg <= 1'b1;
                     sda_drv_reg <= !pwdata[i2cm_pkg::CTL_ACK_LEVEL];
                     cnt_reg <= baud_reg;
                     state_reg <= i2cm_pkg::ST_ACK_LOW;
                  end
               end
            end
            i2cm_pkg::ST_START_WAIT: begin
               if (!line_reg.scl) begin
                  req_reg <= '0;
                  ev_reg.bus_coll <= 1'b1;
                  state_reg <= i2cm_pkg::ST_IDLE;
               end else if (expired) begin
                  if (line_reg.sda) begin
                     sda_drv_reg <= 1'b1;
                     ev_reg.start_det <= 1'b1;
                     cnt_reg <= baud_reg;
                     state_reg <= i2cm_pkg::ST_START_HOLD;
                  end else begin
                     req_reg <= '0;
                     ev_reg.bus_coll <= 1'b1;
                     state_reg <= i2cm_pkg::ST_IDLE;
                  end
               end
            end
            i2cm_pkg::ST_START_HOLD: begin
               if (expired) begin
                  req_reg[i2cm_pkg::CTL_START] <= 1'b0;
                  ev_reg.ser_int <= 1'b1;
                  state_reg <= i2cm_pkg::ST_IDLE;
               end
            end
            i2cm_pkg::ST_RS_LOW: begin
               if (!line_reg.scl) begin
                  sda_drv_reg <= 1'b0;
                  cnt_reg <= baud_reg;
                  state_reg <= i2cm_pkg::ST_RS_SDA_HI;
               end
            end
            i2cm_pkg::ST_RS_SDA_HI: begin
               if (expired) begin
                  if (line_reg.sda) begin
                     scl_drv_reg <= 1'b0;
                     state_reg <= i2cm_pkg::ST_RS_RISE;
                  end else begin
                     req_reg <= '0;
                     scl_drv_reg <= 1'b0;
                     ev_reg.bus_coll <= 1'b1;
                     state_reg <= i2cm_pkg::ST_IDLE;
                  end
               end
            end
            i2cm_pkg::ST_RS_RISE: begin
               if (line_reg.scl) begin
                  if (!line_reg.sda) begin
                     req_reg <= '0;
                     ev_reg.bus_coll <= 1'b1;
                     state_reg <= i2cm_pkg::ST_IDLE;
                  end else begin
                     cnt_reg <= baud_reg;
                     state_reg <= i2cm_pkg::ST_RS_BOTH_HI;
                  end
               end
            end
            i2cm_pkg::ST_RS_BOTH_HI: begin
               if (!line_reg.scl || !line_reg.sda) begin
                  req_reg <= '0;
                  ev_reg.bus_coll <= 1'b1;
                  state_reg <= i2cm_pkg::ST_IDLE;
               end else if (expired) begin
                  sda_drv_reg <= 1'b1;
                  ev_reg.start_det <= 1'b1;
                  cnt_reg <= baud_reg;
                  state_reg <= i2cm_pkg::ST_RS_SDA_LO;
               end
            end
            i2cm_pkg::ST_RS_SDA_LO: begin
               if (expired) begin
                  scl_drv_reg <= 1'b1;
                  req_reg[i2cm_pkg::CTL_RESTART] <= 1'b0;
                  ev_reg.ser_int <= 1'b1;
                  state_reg <= i2cm_pkg::ST_IDLE;
               end
            end
            i2cm_pkg::ST_TX_LOW: begin
               if (bit_reg == i2cm_pkg::ACK_SLOT) begin
                  sda_drv_reg <= 1'b0;
               end else begin
                  sda_drv_reg <= !shift_reg[7];
               end
               if (expired) begin
                  scl_drv_reg <= 1'b0;
                  state_reg <= i2cm_pkg::ST_TX_RISE;
               end
            end
            i2cm_pkg::ST_TX_RISE: begin
               if (line_reg.scl) begin
                  cnt_reg <= baud_reg;
                  state_reg <= i2cm_pkg::ST_TX_HIGH;
               end
            end
            i2cm_pkg::ST_TX_HIGH: begin
               if (expired) begin
                  scl_drv_reg <= 1'b1;
                  shift_reg <= {shift_reg[6:0], 1'b0};
                  if (bit_reg == i2cm_pkg::ACK_SLOT) begin
                     ev_reg.ack_cap <= 1'b1;
                     ev_reg.ack_val <= line_reg.sda;
                     ev_reg.ser_int <= 1'b1;
                     state_reg <= i2cm_pkg::ST_IDLE;
                  end else begin
                     if (bit_reg == i2cm_pkg::LAST_BIT) begin
                        ev_reg.bf_clr <= 1'b1;
                     end
                     bit_reg <= bit_reg + 1'b1;
                     cnt_reg <= baud_reg;
                     state_reg <= i2cm_pkg::ST_TX_LOW;
                  end
               end
            end
            i2cm_pkg::ST_RX_LOW: begin
               if (expired) begin
                  scl_drv_reg <= 1'b0;
                  state_reg <= i2cm_pkg::ST_RX_RISE;
               end
            end
            i2cm_pkg::ST_RX_RISE: begin
               if (line_reg.scl) begin
                  cnt_reg <= baud_reg;
                  state_reg <= i2cm_pkg::ST_RX_HIGH;
               end
            end
            i2cm_pkg::ST_RX_HIGH: begin
               if (expired) begin
                  scl_drv_reg <= 1'b1;
                  shift_reg <= {shift_reg[6:0], line_reg.sda};
                  if (bit_reg == i2cm_pkg::LAST_BIT) begin
                     buf_reg <= {shift_reg[6:0], line_reg.sda};
                     req_reg[i2cm_pkg::CTL_RECEIVE] <= 1'b0;
                     ev_reg.rx_done <= 1'b1;
                     ev_reg.ser_int <= 1'b1;
                     state_reg <= i2cm_pkg::ST_IDLE;
                  end else begin
                     bit_reg <= bit_reg + 1'b1;
                     cnt_reg <= baud_reg;
                     state_reg <= i2cm_pkg::ST_RX_LOW;
                  end
               end
            end
            i2cm_pkg::ST_ACK_LOW: begin
               if (expired) begin
                  scl_drv_reg <= 1'b0;
                  state_reg <= i2cm_pkg::ST_ACK_RISE;
               end
            end
            i2cm_pkg::ST_ACK_RISE: begin
               if (line_reg.scl) begin
                  cnt_reg <= baud_reg;
                  state_reg <= i2cm_pkg::ST_ACK_HIGH;
               end
            end
            i2cm_pkg::ST_ACK_HIGH: begin
               if (expired) begin
                  scl_drv_reg <= 1'b1;
                  req_reg[i2cm_pkg::CTL_ACK] <= 1'b0;
                  ev_reg.ser_int <= 1'b1;
                  state_reg <= i2cm_pkg::ST_IDLE;
               end
            end
            i2cm_pkg::ST_SP_LOW: begin
               if (expired && !line_reg.sda) begin
                  scl_drv_reg <= 1'b0;
                  state_reg <= i2cm_pkg::ST_SP_RISE;
               end
            end
            i2cm_pkg::ST_SP_RISE: begin
               if (line_reg.scl) begin
                  cnt_reg <= baud_reg;
                  state_reg <= i2cm_pkg::ST_SP_HIGH;
               end
            end
            i2cm_pkg::ST_SP_HIGH: begin
               if (expired) begin
                  sda_drv_reg <= 1'b0;
                  cnt_reg <= baud_reg;
                  state_reg <= i2cm_pkg::ST_SP_END;
               end
            end
            i2cm_pkg::ST_SP_END: begin
               if (expired) begin
                  ev_reg.stop_det <= line_reg.scl && line_reg.sda;
                  req_reg[i2cm_pkg::CTL_STOP] <= 1'b0;
                  ev_reg.ser_int <= 1'b1;
                  state_reg <= i2cm_pkg::ST_IDLE;
               end
            end
            default: begin
               scl_drv_reg <= 1'b0;
               sda_drv_reg <= 1'b0;
               req_reg <= '0;
               state_reg <= i2cm_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // Buffer-full and received-byte tracking
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         buf_full_reg <= 1'b0;
         rx_byte_reg <= 1'b0;
      end else begin
         if (wr_acc && paddr == i2cm_pkg::OFS_DATA && idle) begin
            buf_full_reg <= 1'b1;
            rx_byte_reg <= 1'b0;
         end else if (ev_reg.rx_done) begin
            buf_full_reg <= 1'b1;
            rx_byte_reg <= 1'b1;
         end else if (ev_reg.bf_clr) begin
            buf_full_reg <= 1'b0;
         end else if (rd_acc && paddr == i2cm_pkg::OFS_DATA &&
               rx_byte_reg) begin
            buf_full_reg <= 1'b0;
         end
      end
   end

   // Status flags, sticky except peer acknowledge; a hardware set wins over a software clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         peer_ack_reg <= 1'b0;
         wr_coll_reg <= 1'b0;
         rx_ovf_reg <= 1'b0;
         ser_int_reg <= 1'b0;
         bus_coll_reg <= 1'b0;
         start_det_reg <= 1'b0;
         stop_det_reg <= 1'b0;
      end else begin
         if (ev_reg.ack_cap) begin
            peer_ack_reg <= ev_reg.ack_val;
         end
         wr_coll_reg <= (wr_acc && paddr == i2cm_pkg::OFS_DATA && !idle)
            || (wr_coll_reg && !status_w1c[i2cm_pkg::STA_WR_COLL]);
         rx_ovf_reg <= (ev_reg.rx_done && buf_full_reg)
            || (rx_ovf_reg && !status_w1c[i2cm_pkg::STA_RX_OVF]);
         ser_int_reg <= ev_reg.ser_int
            || (ser_int_reg && !status_w1c[i2cm_pkg::STA_SER_INT]);
         bus_coll_reg <= ev_reg.bus_coll
            || (bus_coll_reg && !status_w1c[i2cm_pkg::STA_BUS_COLL]);
         start_det_reg <= ev_reg.start_det
            || (start_det_reg && !status_w1c[i2cm_pkg::STA_START_DET]);
         stop_det_reg <= ev_reg.stop_det
            || (stop_det_reg && !status_w1c[i2cm_pkg::STA_STOP_DET]);
      end
   end

   // APB read data and error, captured in the setup cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_reg <= '0;
         pslverr_reg <= 1'b0;
      end else if (setup) begin
         prdata_reg <= '0;
         pslverr_reg <= 1'b0;
         case (paddr)
            i2cm_pkg::OFS_CTRL: prdata_reg[5:0] <= req_reg;
            i2cm_pkg::OFS_STATUS: begin
               prdata_reg[i2cm_pkg::STA_PEER_ACK] <= peer_ack_reg;
               prdata_reg[i2cm_pkg::STA_BUF_FULL] <= buf_full_reg;
               prdata_reg[i2cm_pkg::STA_WR_COLL] <= wr_coll_reg;
               prdata_reg[i2cm_pkg::STA_RX_OVF] <= rx_ovf_reg;
               prdata_reg[i2cm_pkg::STA_SER_INT] <= ser_int_reg;
               prdata_reg[i2cm_pkg::STA_BUS_COLL] <= bus_coll_reg;
               prdata_reg[i2cm_pkg::STA_START_DET] <= start_det_reg;
               prdata_reg[i2cm_pkg::STA_STOP_DET] <= stop_det_reg;
               prdata_reg[i2cm_pkg::STA_BUSY] <= !idle;
            end
            i2cm_pkg::OFS_BAUD: prdata_reg[BAUD_W-1:0] <= baud_reg;
            i2cm_pkg::OFS_DATA: prdata_reg[7:0] <= buf_reg;
            default: pslverr_reg <= 1'b1;
         endcase
      end
   end

endmodule // i2cm_sequencer

// File: testbench/i2cm_seq_sva.sv
// Port checker for the I2C master sequencer.
// Bound to every sequencer instance; sees its ports only.
module i2cm_seq_sva (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic scl_in,
   input wire logic scl_out,
   input wire logic scl_oe_n,
   input wire logic sda_out,
   input wire logic sda_oe_n
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic acc;
   logic mapped;
   assign acc = psel && penable;
   assign mapped = paddr inside {8'h00, 8'h04, 8'h08, 8'h0c};
   // Start written while both pins are released
   sequence s_go;
      acc && pwrite && paddr == 8'h00 && pwdata[0] && sda_oe_n && scl_oe_n;
   endsequence
   sequence s_clk_low;
      !scl_in && !$past(scl_in) && !$past(scl_in, 2);
   endsequence
   property p_ready; pready; endproperty
   a_ready: assert property (p_ready) else $error("wait state seen");
   property p_slverr; acc |-> pslverr == !mapped; endproperty
   a_slverr: assert property (p_slverr) else $error("bad slave error");
   property p_upper;
      acc && !pwrite && mapped |-> prdata[31:9] == 0;
   endproperty
   a_upper: assert property (p_upper) else $error("upper read bits set");
   property p_start_hold; s_go |=> sda_oe_n [*2]; endproperty
   a_start_hold: assert property (p_start_hold)
      else $error("early start");
   property p_coll; s_go ##0 s_clk_low |=> sda_oe_n [*8]; endproperty
   a_coll: assert property (p_coll) else $error("start on low clock");
   property p_start_edge; $fell(sda_oe_n) && scl_oe_n |-> scl_in; endproperty
   a_start_edge: assert property (p_start_edge)
      else $error("bad start");
   // Open-drain pins only ever pull low
   property p_open_drain; !scl_out && !sda_out; endproperty
   a_open_drain: assert property (p_open_drain)
      else $error("pin value not low");
   // Bench keeps the baud reload at 1 or more
   property p_scl_low; $fell(scl_oe_n) |-> !scl_oe_n [*2]; endproperty
   a_scl_low: assert property (p_scl_low) else $error("short low");
   property p_scl_high; $rose(scl_oe_n) |-> scl_oe_n [*3]; endproperty
   a_scl_high: assert property (p_scl_high) else $error("short high");
endmodule // i2cm_seq_sva

bind i2cm_sequencer i2cm_seq_sva u_sva (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .scl_in(scl_in), .scl_out(scl_out), .scl_oe_n(scl_oe_n),
   .sda_out(sda_out), .sda_oe_n(sda_oe_n));

// File: testbench/i2cm_slave_model.sv
// Behavioural I2C slave: acks written bytes, sends tx_byte on reads.
// Assumes the bench resolves both lines with pull-ups.
module i2cm_slave_model (
   input wire logic scl,
   input wire logic sda,
   output logic sda_oe_n,
   input wire logic nack,
   input wire logic [7:0] tx_byte,
   output logic [7:0] rx_last
);
   timeunit 1ns;
   timeprecision 100ps;
   int cnt = 0;
   logic rd = 0;
   logic first = 0;
   logic [7:0] sh = 8'h00;
   initial sda_oe_n = 1'b1;
   initial rx_last = 8'h00;
   always @(negedge sda) if (scl) begin // Start or repeated start
      cnt = 0;
      rd = 0;
      first = 1;
   end
   always @(posedge sda) if (scl) begin // Stop
      cnt = 0;
      rd = 0;
   end
   always @(posedge scl) begin
      cnt = cnt + 1;
      if (cnt <= 8) sh = {sh[6:0], sda};
      if (cnt == 9 && sda) rd = 0; // Master declined more data
   end
   always @(negedge scl) begin
      if (cnt == 9) begin
         cnt = 0;
         rx_last = sh;
         if (first) rd = sh[0];
         first = 0;
      end
      if (rd && cnt < 8) sda_oe_n = tx_byte[7 - cnt];
      else sda_oe_n = !(cnt == 8 && !rd && !nack);
   end
endmodule // i2cm_slave_model

// File: testbench/test_i2c_master_sequencer.sv
// Self-checking bench for the I2C master sequencer over APB.
// Assumes pull-ups on both lines and one slave model on the bus.
module test_i2c_master_sequencer;
   timeunit 1ns;
   timeprecision 100ps;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0] paddr = 8'h00, tx = 8'h00, rx, a;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, err, scl_oe_n, sda_oe_n, s_oe_n;
   logic hold = 0, nack = 0;
   int fails = 0, n_tests = 0, cyc = 0;
   wire scl_w = scl_oe_n & ~hold;
   wire sda_w = sda_oe_n & s_oe_n;
   i2cm_sequencer dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_in(scl_w),
      .scl_out(), .scl_oe_n(scl_oe_n), .sda_in(sda_w), .sda_out(),
      .sda_oe_n(sda_oe_n));
   i2cm_slave_model peer (.scl(scl_w), .sda(sda_w), .sda_oe_n(s_oe_n),
      .nack(nack), .tx_byte(tx), .rx_last(rx));
   always #12.5 pclk = ~pclk;
   always @(posedge pclk) if (++cyc == 20000) begin
      fails++;
      wrap_up();
   end
   task automatic wrap_up();
      $display("tests=%0d fails=%0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_tests++;
      if (g !== e) begin
         fails++;
         $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] ad,
         input logic [31:0] d);
      @(posedge pclk);
      psel <= 1;
      pwrite <= w;
      paddr <= ad;
      pwdata <= d;
      @(posedge pclk) penable <= 1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   task automatic rc(input logic [7:0] ad, input logic [31:0] m, e);
      bus(0, ad, 0);
      chk(rd & m, e);
   endtask
   task automatic go(input logic [7:0] ad, input logic [31:0] d);
      bus(1, ad, d);
      do bus(0, 8'h04, 0); while (rd[8] !== 1'b0);
   endtask
   initial begin
      void'($urandom(32'h1e6e70fc));
      repeat (8) @(posedge pclk);
      presetn <= 1;
      rc(8'h08, 32'hffffffff, 32'h9);
      bus(0, 8'h10, 0);
      chk(err, 1);
      bus(1, 8'h08, 1 + $urandom % 3);
      a = 8'($urandom) & 8'hfe;
      tx = 8'($urandom);
      go(8'h00, 1);
      rc(8'h04, 32'h1fe, 32'h50);
      bus(1, 8'h04, 32'hfc);
      bus(1, 8'h0c, {24'h0, a});
      rc(8'h04, 32'h102, 32'h102);
      bus(1, 8'h00, 2);
      bus(1, 8'h00, 8);
      bus(1, 8'h0c, 32'hff);
      rc(8'h00, 32'h3f, 0);
      go(8'h04, 0);
      rc(8'h04, 32'h17, 32'h14);
      chk(rx, a);
      for (int i = 0; i < 2; i++) begin
         nack = i[0];
         bus(1, 8'h04, 32'hfc);
         a = 8'($urandom);
         go(8'h0c, {24'h0, a});
         rc(8'h04, 32'h17, {31'h0, i[0]} | 32'h10);
         chk(rx, a);
      end
      nack = 0;
      bus(1, 8'h04, 32'hfc);
      go(8'h00, 2);
      rc(8'h04, 32'h70, 32'h50);
      go(8'h0c, {24'h0, a | 8'h01});
      go(8'h00, 8);
      rc(8'h04, 32'h0a, 32'h02);
      go(8'h00, 32'h10);
      go(8'h00, 8);
      rc(8'h04, 32'h0a, 32'h0a);
      rc(8'h0c, 32'hff, {24'h0, tx});
      rc(8'h04, 32'h02, 0);
      go(8'h00, 32'h30);
      bus(1, 8'h04, 32'hfc);
      go(8'h00, 4);
      rc(8'h04, 32'h90, 32'h90);
      hold <= 1;
      bus(1, 8'h04, 32'hfc);
      go(8'h00, 1);
      rc(8'h04, 32'h60, 32'h20);
      hold <= 0;
      wrap_up();
   end
endmodule // test_i2c_master_sequencer
